// file: hbp_pkg.sv
// Shared constants for the host bus port
package hbp_pkg;

  // ----------------------------------------------------------------
  // Widths and spaces
  // ----------------------------------------------------------------
  localparam int          ADDR_W        = 18;
  localparam int          DATA_W        = 16;
  localparam int          MEM_WORDS     = 16;
  localparam int          MEM_IDX_W     = 4;
  localparam logic        SPACE_REG     = 1'b0;
  localparam logic        SPACE_MEM     = 1'b1;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ       = 100;
  localparam logic [3:0]  ACCESS_CYC    = 4'h3;
  localparam logic [3:0]  HOST_WAIT_MAX = 4'h6;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] DATA_RST      = 16'h0000;
  localparam logic [17:0] ADDR_RST      = 18'h00000;

endpackage : hbp_pkg

// file: hbp_if.sv
// Interface joining the host and the device end of the host bus port
`timescale 1ns/1ns
`default_nettype none
interface hbp_if;
  logic        [17:0] host_addr_in;
  logic        [15:0] hostDataOut;
  logic               hostDataOe;
  logic        [15:0] devDataOut;
  logic               devDataOe;
  logic        [15:0] host_data_io;
  logic               csN;
  logic               memRegSel;
  logic               low_byte_write_n;
  logic               high_byte_write_n;
  logic               readN;
  logic               rdWrN;
  logic               bus_start_n;
  logic               waitOut;
  logic               bus_clock_in;
  logic               endian_strap;
  logic               hold_polarity_strap;
  logic               clock_divide_strap;
  logic               reserved_strap;

  // Resolved data bus level
  assign host_data_io = devDataOe ? devDataOut :
                        (hostDataOe ? hostDataOut : 16'hffff);

  modport dev
  (
    input  host_addr_in, host_data_io, csN, memRegSel, low_byte_write_n,
           high_byte_write_n, readN, rdWrN, bus_start_n, bus_clock_in,
           endian_strap, hold_polarity_strap, clock_divide_strap,
           reserved_strap,
    output devDataOut, devDataOe, waitOut
  );
  modport host
  (
    input  host_data_io, waitOut,
    output host_addr_in, hostDataOut, hostDataOe, csN, memRegSel,
           low_byte_write_n, high_byte_write_n, readN, rdWrN,
           bus_start_n, bus_clock_in, endian_strap, hold_polarity_strap,
           clock_divide_strap, reserved_strap
  );
endinterface : hbp_if
`default_nettype wire

// file: hbp_device.sv
// Device end of the host bus port: strap latch, decode, wait, storage
`timescale 1ns/1ns
`default_nettype none
module hbp_device
  import hbp_pkg::*;
#(
  parameter int MEM_DEPTH = MEM_WORDS
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  hbp_if.dev               bus,
  output logic             bigEndian,
  output logic             waitActiveHigh,
  output logic             clockDivide,
  output logic             modeValid,
  output logic             busTick,
  output logic             lastWrite,
  output logic             lastSpace,
  output logic [15:0]      lastData
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, BUSY, DONE} hbp_dstate_t;

  typedef struct packed {
    hbp_dstate_t state;
    logic        strapsTaken;
    logic        bigEndian;
    logic        waitHigh;
    logic        divide;
    logic        modeValid;
    logic        divPhase;
    logic        busTick;
    logic [3:0]  count;
    logic [15:0] rdData;
    logic        dataOe;
    logic        waitOut;
    logic        lastWrite;
    logic        lastSpace;
    logic [15:0] lastData;
  } hbp_dev_t;

  hbp_dev_t st_reg;
  hbp_dev_t st_next;

  logic [15:0] regMem [MEM_DEPTH];
  logic [15:0] dispMem [MEM_DEPTH];
  logic [MEM_IDX_W-1:0] idx;
  logic        wrLo;
  logic        wrHi;
  logic        rd;
  logic        active;
  logic [15:0] rdWord;

  assign idx    = bus.host_addr_in[MEM_IDX_W:1];
  assign active = !bus.csN;
  assign wrLo   = active && !bus.low_byte_write_n;
  assign wrHi   = active && !bus.high_byte_write_n;
  assign rd     = active && !bus.readN && !wrLo && !wrHi;
  // Register space low, display space high
  assign rdWord = (bus.memRegSel == SPACE_MEM) ? dispMem[idx]
                                               : regMem[idx];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // Straps caught on first clock after reset release
    if (!st_reg.strapsTaken)
    begin
      st_next.strapsTaken = 1'b1;
      st_next.bigEndian   = bus.endian_strap;
      st_next.waitHigh    = bus.hold_polarity_strap;
      st_next.divide      = bus.clock_divide_strap;
      st_next.modeValid   = bus.reserved_strap;
    end
    // Internal bus tick, every cycle or every other
    st_next.divPhase = !st_reg.divPhase;
    st_next.busTick  = !st_reg.divide || st_reg.divPhase;
    case (st_reg.state)
      IDLE:
      begin
        st_next.dataOe = 1'b0;
        if (st_reg.strapsTaken && (wrLo || wrHi || rd))
        begin
          st_next.state = BUSY;
          st_next.count = ACCESS_CYC;
        end
      end
      BUSY:
      begin
        if (!active)
          st_next.state = IDLE;
        else if (st_reg.busTick)
        begin
          if (st_reg.count == 4'h0)
          begin
            st_next.state     = DONE;
            st_next.rdData    = rdWord;
            st_next.dataOe    = rd;
            st_next.lastWrite = !rd;
            st_next.lastSpace = bus.memRegSel;
            st_next.lastData  = rd ? rdWord : bus.host_data_io;
          end
          else
            st_next.count = st_reg.count - 4'h1;
        end
      end
      DONE:
      begin
        // Hold until host ends the cycle
        if (!active || (bus.readN && bus.low_byte_write_n
                        && bus.high_byte_write_n))
        begin
          st_next.state  = IDLE;
          st_next.dataOe = 1'b0;
        end
      end
      default:
        st_next.state = IDLE;
    endcase
    // Wait asserted while busy; polarity from strap
    st_next.waitOut = (st_next.state == BUSY) ? st_next.waitHigh
                                              : !st_next.waitHigh;
  end

  // ----------------------------------------------------------------
  // Registers and storage
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg         <= '0;
      st_reg.state   <= IDLE;
      st_reg.waitOut <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  always_ff @(posedge clk)
  begin
    if (st_reg.state == BUSY && st_next.state == DONE && !rd)
    begin
      if (bus.memRegSel == SPACE_MEM)
      begin
        if (wrLo)
          dispMem[idx][7:0] <= bus.host_data_io[7:0];
        if (wrHi)
          dispMem[idx][15:8] <= bus.host_data_io[15:8];
      end
      else
      begin
        if (wrLo)
          regMem[idx][7:0] <= bus.host_data_io[7:0];
        if (wrHi)
          regMem[idx][15:8] <= bus.host_data_io[15:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs; direction and bus start inputs are not looked at
  // ----------------------------------------------------------------
  assign bus.devDataOut = st_reg.rdData;
  assign bus.devDataOe  = st_reg.dataOe && active && !bus.readN;
  assign bus.waitOut    = st_reg.waitOut;
  assign bigEndian      = st_reg.bigEndian;
  assign waitActiveHigh = st_reg.waitHigh;
  assign clockDivide    = st_reg.divide;
  assign modeValid      = st_reg.modeValid;
  assign busTick        = st_reg.busTick;
  assign lastWrite      = st_reg.lastWrite;
  assign lastSpace      = st_reg.lastSpace;
  assign lastData       = st_reg.lastData;

endmodule : hbp_device
`default_nettype wire

// file: hbp_host.sv
// Host end of the host bus port: chip select unit driving strobes
`timescale 1ns/1ns
`default_nettype none
module hbp_host
  import hbp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  hbp_if.host              bus,
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic        reqSpace,
  input  wire logic [1:0]  reqBytes,
  input  wire logic [17:0] reqAddr,
  input  wire logic [15:0] reqData,
  input  wire logic        useAck,
  input  wire logic [3:0]  waitStates,
  input  wire logic        ackHigh,
  input  wire logic        strapDivide,
  output logic             busy,
  output logic             done,
  output logic [15:0]      rdData
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, ACCESS, FINISH} hbp_hstate_t;

  typedef struct packed {
    hbp_hstate_t state;
    logic [17:0] addr;
    logic [15:0] wdata;
    logic        write;
    logic        space;
    logic [1:0]  bytes;
    logic [3:0]  count;
    logic        armed;
    logic        busy;
    logic        done;
    logic [15:0] rdData;
  } hbp_host_t;

  hbp_host_t st_reg;
  hbp_host_t st_next;
  logic      ackSeen;
  logic      inAcc;

  assign ackSeen = (bus.waitOut == !ackHigh);
  assign inAcc   = (st_reg.state == ACCESS);

  always_comb
  begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    case (st_reg.state)
      IDLE:
        if (reqValid)
        begin
          st_next.state = ACCESS;
          st_next.addr  = reqAddr;
          st_next.wdata = reqData;
          st_next.write = reqWrite;
          st_next.space = reqSpace;
          st_next.bytes = reqWrite ? reqBytes : 2'b00;
          st_next.count = (waitStates > HOST_WAIT_MAX) ? HOST_WAIT_MAX
                                                       : waitStates;
          st_next.armed = 1'b0;
          st_next.busy  = 1'b1;
        end
      ACCESS:
      begin
        // Acknowledge or fixed wait states end the cycle
        // Wait line not looked at before the device can answer
        st_next.armed = 1'b1;
        if (useAck ? (st_reg.armed && ackSeen)
                   : (st_reg.count == 4'h0))
        begin
          st_next.state  = FINISH;
          st_next.rdData = bus.host_data_io;
        end
        else if (st_reg.count != 4'h0)
          st_next.count = st_reg.count - 4'h1;
      end
      FINISH:
      begin
        st_next.state = IDLE;
        st_next.busy  = 1'b0;
        st_next.done  = 1'b1;
      end
      default:
        st_next.state = IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg       <= '0;
      st_reg.state <= IDLE;
    end
    else
      st_reg <= st_next;
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign bus.host_addr_in        = st_reg.addr;
  assign bus.hostDataOut         = st_reg.wdata;
  assign bus.hostDataOe          = inAcc && st_reg.write;
  assign bus.csN                 = !inAcc;
  assign bus.memRegSel           = st_reg.space;
  assign bus.low_byte_write_n    = !(inAcc && st_reg.bytes[0]);
  assign bus.high_byte_write_n   = !(inAcc && st_reg.bytes[1]);
  assign bus.readN               = !(inAcc && !st_reg.write);
  assign bus.rdWrN               = 1'b1;
  assign bus.bus_start_n         = 1'b1;
  assign bus.bus_clock_in        = clk;
  assign bus.endian_strap        = 1'b1;
  assign bus.hold_polarity_strap = ackHigh;
  assign bus.clock_divide_strap  = strapDivide;
  assign bus.reserved_strap      = 1'b1;
  assign busy                    = st_reg.busy;
  assign done                    = st_reg.done;
  assign rdData                  = st_reg.rdData;

endmodule : hbp_host
`default_nettype wire

// file: hbp_properties.sv
// Checker for the host bus port interface
`timescale 1ns/1ns
`default_nettype none
module hbp_properties
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        csN,
  input wire logic        readN,
  input wire logic        low_byte_write_n,
  input wire logic        high_byte_write_n,
  input wire logic        rdWrN,
  input wire logic        bus_start_n,
  input wire logic        waitOut,
  input wire logic        devDataOe,
  input wire logic [17:0] host_addr_in,
  input wire logic        endian_strap,
  input wire logic        reserved_strap,
  input wire logic        hold_polarity_strap
);
  logic waitOn;
  assign waitOn = (waitOut == hold_polarity_strap);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------
  // Properties
  // ------
  property p_idleBus;
    csN |-> !devDataOe;
  endproperty
  a_idleBus: assert property (p_idleBus)
    else $error("bus driven while deselected");
  property p_noWait;
    csN && $past(csN) && $past(rstn, 2) |-> !waitOn;
  endproperty
  a_noWait: assert property (p_noWait)
    else $error("wait active while deselected");
  property p_driveRead;
    devDataOe |-> !csN && !readN;
  endproperty
  a_driveRead: assert property (p_driveRead)
    else $error("bus driven outside a read");
  property p_waitBound;
    $fell(csN) |-> ##[1:30] !waitOn;
  endproperty
  a_waitBound: assert property (p_waitBound)
    else $error("wait not released in time");
  property p_dataAtDone;
    !csN && !readN && $fell(waitOn) |-> devDataOe;
  endproperty
  a_dataAtDone: assert property (p_dataAtDone)
    else $error("read data missing at release");
  property p_stableAddr;
    waitOn && !csN && $past(waitOn) && !$past(csN)
      |-> $stable(host_addr_in);
  endproperty
  a_stableAddr: assert property (p_stableAddr)
    else $error("address moved during wait");
  property p_idleStrobes;
    csN |-> readN && low_byte_write_n && high_byte_write_n;
  endproperty
  a_idleStrobes: assert property (p_idleStrobes)
    else $error("strobe without chip select");
  property p_tiedPins;
    rdWrN && bus_start_n && endian_strap && reserved_strap;
  endproperty
  a_tiedPins: assert property (p_tiedPins)
    else $error("tied input not high");
  c_read: cover property (!csN && !readN && $fell(waitOn));
  c_write: cover property (!csN && !low_byte_write_n && $fell(waitOn));
  c_lowWait: cover property (!hold_polarity_strap && $fell(csN));
endmodule : hbp_properties
`default_nettype wire

// file: hbp_bench.sv
// Self-checking bench joining host and device ends
`timescale 1ns/1ns
`default_nettype none
module hbp_bench;
  typedef struct packed {
    logic        wr;
    logic        space;
    logic [1:0]  bytes;
    logic [17:0] addr;
    logic [15:0] data;
    logic [15:0] exp;
  } hbp_row_t;
  hbp_row_t    rows [8];
  logic        clk, rstn, reqValid, reqWrite, reqSpace, useAck;
  logic        ackHigh, strapDivide, busy, done, lastWrite, lastSpace;
  logic        bigEndian, waitActiveHigh, clockDivide, modeValid;
  logic [1:0]  reqBytes;
  logic [3:0]  waitStates;
  logic [17:0] reqAddr;
  logic [15:0] reqData, rdData, lastData;
  logic        busTick;
  int          nErrors, compares;
  hbp_if busIf ();
  hbp_device i_hbp_device (
    .clk            (clk),
    .rstn           (rstn),
    .bus            (busIf),
    .bigEndian      (bigEndian),
    .waitActiveHigh (waitActiveHigh),
    .clockDivide    (clockDivide),
    .modeValid      (modeValid),
    .busTick        (busTick),
    .lastWrite      (lastWrite),
    .lastSpace      (lastSpace),
    .lastData       (lastData)
  );
  hbp_host i_hbp_host (
    .clk         (clk),
    .rstn        (rstn),
    .bus         (busIf),
    .reqValid    (reqValid),
    .reqWrite    (reqWrite),
    .reqSpace    (reqSpace),
    .reqBytes    (reqBytes),
    .reqAddr     (reqAddr),
    .reqData     (reqData),
    .useAck      (useAck),
    .waitStates  (waitStates),
    .ackHigh     (ackHigh),
    .strapDivide (strapDivide),
    .busy        (busy),
    .done        (done),
    .rdData      (rdData)
  );
  hbp_properties i_hbp_properties (
    .clk                 (clk),
    .rstn                (rstn),
    .csN                 (busIf.csN),
    .readN               (busIf.readN),
    .low_byte_write_n    (busIf.low_byte_write_n),
    .high_byte_write_n   (busIf.high_byte_write_n),
    .rdWrN               (busIf.rdWrN),
    .bus_start_n         (busIf.bus_start_n),
    .waitOut             (busIf.waitOut),
    .devDataOe           (busIf.devDataOe),
    .host_addr_in        (busIf.host_addr_in),
    .endian_strap        (busIf.endian_strap),
    .reserved_strap      (busIf.reserved_strap),
    .hold_polarity_strap (busIf.hold_polarity_strap)
  );
  // ------
  // Tasks
  // ------
  task automatic complete_run();
    $display("compares %0d errors %0d", compares, nErrors);
    if (nErrors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run
  task automatic check(input string name, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      nErrors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic access(input hbp_row_t r);
    int n;
    reqWrite <= r.wr;
    reqSpace <= r.space;
    reqBytes <= r.bytes;
    reqAddr  <= r.addr;
    reqData  <= r.data;
    reqValid <= 1'b1;
    @(posedge clk);
    reqValid <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 200)
    begin
      nErrors++;
      complete_run();
    end
    else
    begin
      if (!r.wr)
        check("rdData", rdData, r.exp);
      check("last", {lastWrite, lastSpace}, {r.wr, r.space});
      check("lastData", lastData, r.wr ? r.data : r.exp);
      @(posedge clk);
    end
  endtask : access
  task automatic doReset(input logic hi, input logic div);
    int ticks;
    rstn        <= 1'b0;
    ackHigh     <= hi;
    strapDivide <= div;
    repeat (10) @(posedge clk);
    check("resetOe", busIf.devDataOe, 1'b0);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check("straps", {bigEndian, waitActiveHigh, clockDivide, modeValid,
      busIf.waitOut}, {1'b1, hi, div, 1'b1, ~hi});
    ticks = 0;
    repeat (8)
    begin
      @(posedge clk);
      ticks += busTick;
    end
    check("ticks", ticks[15:0], div ? 16'h0004 : 16'h0008);
  endtask : doReset
  // ------
  // Stimulus
  // ------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    rstn        = 1'b0;
    reqValid    = 1'b0;
    reqWrite    = 1'b0;
    reqSpace    = 1'b0;
    reqBytes    = 2'h0;
    reqAddr     = 18'h00000;
    reqData     = 16'h0000;
    useAck      = 1'b1;
    waitStates  = 4'h0;
    ackHigh     = 1'b1;
    strapDivide = 1'b0;
    nErrors     = 0;
    compares    = 0;
    rows[0] = '{1'b1, 1'b1, 2'h3, 18'h00002, 16'h1234, 16'h0000};
    rows[1] = '{1'b1, 1'b0, 2'h3, 18'h00002, 16'h5678, 16'h0000};
    rows[2] = '{1'b1, 1'b1, 2'h1, 18'h00002, 16'hffab, 16'h0000};
    rows[3] = '{1'b1, 1'b0, 2'h2, 18'h00002, 16'hcdff, 16'h0000};
    rows[4] = '{1'b0, 1'b1, 2'h3, 18'h00002, 16'h0000, 16'h12ab};
    rows[5] = '{1'b0, 1'b0, 2'h3, 18'h00002, 16'h0000, 16'hcd78};
    rows[6] = '{1'b1, 1'b1, 2'h3, 18'h3fffe, 16'hbeef, 16'h0000};
    rows[7] = '{1'b0, 1'b1, 2'h3, 18'h3fffe, 16'h0000, 16'hbeef};
    doReset(1'b1, 1'b0);
    foreach (rows[i])
      access(rows[i]);
    // Fixed host wait states instead of acknowledge
    useAck     <= 1'b0;
    waitStates <= 4'h6;
    access('{1'b1, 1'b0, 2'h3, 18'h00004, 16'ha5c3, 16'h0000});
    access('{1'b0, 1'b0, 2'h3, 18'h00004, 16'h0000, 16'ha5c3});
    // Divided clock with active-low wait
    useAck <= 1'b1;
    doReset(1'b0, 1'b1);
    access('{1'b1, 1'b1, 2'h3, 18'h00006, 16'h0f1e, 16'h0000});
    access('{1'b0, 1'b1, 2'h3, 18'h00006, 16'h0000, 16'h0f1e});
    complete_run();
  end
endmodule : hbp_bench
`default_nettype wire
